// *** dv/pin_level_duration_measure_tb.sv ***
module pin_level_duration_measure_tb;
    import pldm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [3:0] pin; logic lvl; logic [15:0] hold, exp;} pldm_row_t;
    localparam pldm_row_t ROWS [4] = '{'{4'h0, 1'b1, 16'h0000, 16'h0001},
        '{4'hF, 1'b0, 16'h0008, 16'h0001}, '{4'h7, 1'b1, 16'h0017, 16'h0002},
        '{4'h3, 1'b0, 16'h008F, 16'h000A}};
    logic        sys_clk;
    logic        rst = 1;
    logic        start = 0;
    logic        level = 0;
    logic [3:0]  pinSel = 0;
    logic [15:0] pinDriveOut = 0;
    logic [15:0] pinDriveEn_n = 0;
    logic [15:0] holdCycles = 0;
    wire  [15:0] pinIn, pinOut, pinOe_n, count;
    wire         busy, done;
    int          error_cnt = 0;
    int          checks = 0;
    pin_level_duration_measure #(.UNIT(PLDM_UNIT_0P75US)) dut_u (.*);
    pldm_rc_net net_u (.*);
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic measure(logic [3:0] p, logic l, logic [15:0] h, int pre);
        pinDriveOut = {16{l}};
        holdCycles = h;
        repeat (pre + 1) @(posedge sys_clk);
        #1 start = 1;
        pinSel = p;
        level = l;
        @(posedge sys_clk);
        #1 start = 0;
        for (int n = 0; n < 3000 && done !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
    endtask
    initial begin
        sys_clk = 0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        #1 rst = 0;
        check(pinOe_n, 16'hFFFF);
        check({14'h0000, busy, done}, 16'h0000);
        check(count, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            measure(ROWS[i].pin, ROWS[i].lvl, ROWS[i].hold, 4);
            check(count, ROWS[i].exp);
        end
        // Second start while busy must be ignored
        fork
            measure(4'h0, 1'b1, 16'h0017, 4);
            begin
                repeat (12) @(posedge sys_clk);
                #1 start = 1;
                pinSel = 4'h5;
                level = 1'b0;
                @(posedge sys_clk);
                #1 start = 0;
            end
        join
        check(count, 16'h0002);
        measure(4'h0, 1'b1, 16'h0000, 0);
        check(count, 16'h0001);
        repeat (3) @(posedge sys_clk);
        #1 check(count, 16'h0001);
        // Reset in mid-measurement abandons it
        start = 1;
        pinSel = 4'h2;
        level = 1'b1;
        @(posedge sys_clk);
        #1 start = 0;
        repeat (4) @(posedge sys_clk);
        #1 rst = 1;
        repeat (2) @(posedge sys_clk);
        #1 rst = 0;
        check({14'h0000, busy, done}, 16'h0000);
        check(count, 16'h0000);
        check(pinOe_n, 16'hFFFF);
        measure(4'h0, 1'b1, 16'h0000, 4);
        check(count, 16'h0001);
        print_verdict();
    end
endmodule

// *** dv/pldm_asserts.sv ***
module pldm_asserts
    import pldm_pkg::*;
#(
    parameter pldm_unit_t UNIT = PLDM_UNIT_2US
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        start,
    input wire logic [3:0]  pinSel,
    input wire logic [15:0] pinDriveEn_n,
    input wire logic [15:0] pinOe_n,
    input wire logic        busy,
    input wire logic        done,
    input wire logic [15:0] count
);
    localparam int UC = (UNIT == PLDM_UNIT_2US) ? 40 : (UNIT == PLDM_UNIT_0P8US) ? 16 : 15;
    logic [3:0]  sel_reg;
    logic [31:0] cyc_reg;
    wire         take = start && !busy;
    // Elapsed cycles since the accepted start
    always_ff @(posedge sys_clk) begin
        sel_reg <= take ? pinSel : sel_reg;
        cyc_reg <= take ? 32'h0000_0001 : cyc_reg + 32'h0000_0001;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_start_busy: assert property (take |=> busy)
        else $error("start not taken");
    a_done_pulse: assert property (done |=> !done)
        else $error("done too long");
    a_done_idle: assert property (done |-> !busy)
        else $error("busy at done");
    a_count_hold: assert property (!done && !$past(rst) |-> $stable(count))
        else $error("count moved");
    a_sel_float: assert property (busy && $past(busy) |-> pinOe_n[sel_reg])
        else $error("pin still driven");
    a_idle_drive: assert property (!$past(rst) && !busy && !$past(busy) && !$past(busy, 2)
        |-> pinOe_n == $past(pinDriveEn_n))
        else $error("enable mismatch");
    a_min_time: assert property ($rose(busy) |-> !done [*8])
        else $error("done too early");
    a_unit_count: assert property (done && count != 0 |->
        cyc_reg >= count * UC && cyc_reg <= count * UC + 8)
        else $error("count vs time");
    c_quick: cover property (done && count == 16'h0001);
    c_long: cover property (done && count > 16'h0001);
    c_refused: cover property (start && busy);
endmodule

bind pin_level_duration_measure pldm_asserts #(.UNIT(UNIT)) chk_u (.*);

// *** dv/pldm_rc_net.sv ***
module pldm_rc_net (
    input wire logic        sys_clk,
    input wire logic [15:0] pinOut,
    input wire logic [15:0] pinOe_n,
    input wire logic [15:0] holdCycles,
    output logic     [15:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] chg_reg = 16'h0000;
    logic [15:0] rel_reg = 16'h0000;
    always_ff @(posedge sys_clk) begin
        chg_reg <= ~pinOe_n & pinOut | pinOe_n & chg_reg;
        rel_reg <= (pinOe_n == 16'h0000) ? 16'h0000 : rel_reg + 16'h0001;
    end
    assign pinIn = ~pinOe_n & pinOut | pinOe_n & (rel_reg < holdCycles ? chg_reg : ~chg_reg);
endmodule

// *** src/pin_level_duration_measure.sv ***
`include "pldm_consts.svh"

// Overview of operation
// RQ1 - Pin selector 0..15; selected pin turned to input at measurement start.
// RQ2 - Level operand picks timed level; leaving it ends measurement, stores count.
// RQ3 - Counter advances once per unit: 2, 0.8 or 0.75 microseconds.
// RQ4 - Stop on first timing cycle where sampled pin differs from level.
// RQ5 - Pin already off-level at start reports count of one.
// RQ6 - Level held beyond 65535 cycles ends measurement with count zero.
// RQ7 - Controller precharges network at chosen level, e.g. 1 ms, beforehand.
// RQ8 - Start pulse with operands; done pulse; count held until next start.
module pin_level_duration_measure
    import pldm_pkg::*;
#(
    parameter pldm_unit_t UNIT = PLDM_UNIT_2US
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic                       start,
    input  wire logic [`PLDM_PIN_SEL_W-1:0] pinSel,
    input  wire logic                       level,
    input  wire logic [`PLDM_PIN_COUNT-1:0] pinIn,
    input  wire logic [`PLDM_PIN_COUNT-1:0] pinDriveOut,
    input  wire logic [`PLDM_PIN_COUNT-1:0] pinDriveEn_n,
    output logic      [`PLDM_PIN_COUNT-1:0] pinOut,
    output logic      [`PLDM_PIN_COUNT-1:0] pinOe_n,
    output logic                            busy,
    output logic                            done,
    output logic      [`PLDM_COUNT_W-1:0]   count
);
    // Whole clocks per unit at 50 ns: 40, 16 or 15; no fractional units needed
    localparam longint unsigned UNIT_PS =
        (UNIT == PLDM_UNIT_0P8US)  ? `PLDM_UNIT_0P8US_PS :
        (UNIT == PLDM_UNIT_0P75US) ? `PLDM_UNIT_0P75US_PS : `PLDM_UNIT_2US_PS;
    localparam int unsigned UNIT_CYCLES = int'(UNIT_PS / `PLDM_CLK_PERIOD_PS);

    pldm_state_t                 state_reg, state_next;
    logic [`PLDM_PIN_COUNT-1:0]  sync1_reg, sync2_reg;
    logic [`PLDM_PIN_SEL_W-1:0]  sel_reg;
    logic                        level_reg;
    logic [`PLDM_COUNT_W-1:0]    cycles_reg, cycles_next;
    logic [`PLDM_COUNT_W-1:0]    count_reg, count_next;
    logic                        done_reg;
    logic                        busy_reg;
    logic [`PLDM_PIN_COUNT-1:0]  pinOut_reg, pinOe_n_reg;
    logic                        unitTick;

    // Pins are off-domain: two stages before any reader
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pinIn;
            sync2_reg <= sync1_reg;
        end
    end

    wire logic inMeasure  = (state_reg == PLDM_MEASURE);
    wire logic takeStart  = start && (state_reg == PLDM_IDLE);
    wire logic pinLevel   = sync2_reg[sel_reg];
    // Sampled once per timing unit
    wire logic offLevel   = (pinLevel != level_reg);
    wire logic atMax      = (cycles_reg == `PLDM_COUNT_MAX);
    wire logic finish     = inMeasure && unitTick && (offLevel || atMax);

    // RQ3 unit divider
    pldm_unit_tick #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_tick (
        .sys_clk(sys_clk),
        .rst    (rst),
        .run    (inMeasure),
        .tick   (unitTick)
    );

    always_comb begin
        state_next  = state_reg;
        cycles_next = cycles_reg;
        count_next  = count_reg;
        unique case (state_reg)
            PLDM_IDLE: begin
                if (takeStart) begin
                    state_next = PLDM_SETTLE;
                end
            end
            // Give the input switch one cycle to reach the synchroniser
            PLDM_SETTLE: begin
                state_next  = PLDM_MEASURE;
                cycles_next = `PLDM_COUNT_ZERO;
            end
            PLDM_MEASURE: begin
                if (unitTick) begin
                    cycles_next = cycles_reg + `PLDM_COUNT_ONE;
                end
                if (finish) begin
                    state_next = PLDM_IDLE;
                    // RQ6 overflow zero
                    if (!offLevel && atMax) begin
                        count_next = `PLDM_COUNT_ZERO;
                    // RQ5 RQ4 stop count
                    end else begin
                        count_next = cycles_reg + `PLDM_COUNT_ONE;
                    end
                end
            end
            default: state_next = PLDM_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg  <= PLDM_IDLE;
            sel_reg    <= '0;
            level_reg  <= 1'b0;
            cycles_reg <= `PLDM_COUNT_ZERO;
            count_reg  <= `PLDM_COUNT_ZERO;
            done_reg   <= 1'b0;
            busy_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            // Registered so the output comes straight from a flop
            busy_reg   <= (state_next != PLDM_IDLE);
            cycles_reg <= cycles_next;
            // RQ8 held result
            count_reg  <= count_next;
            done_reg   <= finish;
            // RQ1 RQ2 latch operands
            if (takeStart) begin
                sel_reg   <= pinSel;
                level_reg <= level;
            end
        end
    end

    // One-hot pin mask, kept at the pin count width
    function automatic logic [`PLDM_PIN_COUNT-1:0] pinMask(
        input logic [`PLDM_PIN_SEL_W-1:0] sel
    );
        logic [`PLDM_PIN_COUNT-1:0] one;
        one = {{(`PLDM_PIN_COUNT-1){1'b0}}, 1'b1};
        return one << sel;
    endfunction

    // RQ1 input mode during measurement
    wire logic [`PLDM_PIN_COUNT-1:0] releaseMask =
        (state_reg != PLDM_IDLE) ? pinMask(sel_reg) : '0;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pinOut_reg  <= '0;
            pinOe_n_reg <= `PLDM_PIN_ALL_OUT;
        end else begin
            pinOut_reg  <= pinDriveOut;
            pinOe_n_reg <= pinDriveEn_n | releaseMask;
        end
    end

    assign pinOut  = pinOut_reg;
    assign pinOe_n = pinOe_n_reg;
    assign busy    = busy_reg;
    assign done    = done_reg;
    assign count   = count_reg;
endmodule

// *** src/pldm_consts.svh ***
`ifndef PLDM_CONSTS_SVH
`define PLDM_CONSTS_SVH

// Clock period in picoseconds
`define PLDM_CLK_PERIOD_PS   32'h0000_C350
// Timing unit variants in picoseconds: 2 us, 0.8 us, 0.75 us
`define PLDM_UNIT_2US_PS     (32'h0000_07D0 * 32'h0000_03E8)
`define PLDM_UNIT_0P8US_PS   (32'h0000_0320 * 32'h0000_03E8)
`define PLDM_UNIT_0P75US_PS  (32'h0000_02EE * 32'h0000_03E8)
`define PLDM_PIN_COUNT       32'h0000_0010
`define PLDM_PIN_SEL_W       4
`define PLDM_COUNT_W         16
`define PLDM_COUNT_MAX       16'hFFFF
`define PLDM_COUNT_ZERO      16'h0000
`define PLDM_COUNT_ONE       16'h0001
`define PLDM_PIN_ALL_OUT     16'hFFFF
`define PLDM_TICK_W          8

`endif

// *** src/pldm_pkg.sv ***
package pldm_pkg;
    typedef enum logic [1:0] {
        PLDM_IDLE    = 2'b00,
        PLDM_SETTLE  = 2'b01,
        PLDM_MEASURE = 2'b11
    } pldm_state_t;

    typedef enum logic [1:0] {
        PLDM_UNIT_2US   = 2'b00,
        PLDM_UNIT_0P8US = 2'b01,
        PLDM_UNIT_0P75US = 2'b10
    } pldm_unit_t;
endpackage

// *** src/pldm_unit_tick.sv ***
`include "pldm_consts.svh"

// Divider cleared while run is low, restarting from zero; one pulse per timing unit while enabled
module pldm_unit_tick
    import pldm_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = 40
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic run,
    output logic      tick
);
    localparam logic [`PLDM_TICK_W-1:0] LAST = `PLDM_TICK_W'(UNIT_CYCLES - 1);

    logic [`PLDM_TICK_W-1:0] divCount_reg;
    logic                    tick_reg;
    wire  logic              atLast = (divCount_reg == LAST);

    always_ff @(posedge sys_clk) begin
        if (rst || !run) begin
            divCount_reg <= '0;
            tick_reg     <= 1'b0;
        end else begin
            divCount_reg <= atLast ? '0 : divCount_reg + 1'b1;
            tick_reg     <= atLast;
        end
    end

    assign tick = tick_reg;
endmodule
